// ==== rtl/adcc_regs.vh ====
`ifndef ADCC_REGS_VH
`define ADCC_REGS_VH
// ==========================================
// Bus formats on the two select pins
`define ADCC_FMT_PAR18     2'h0
`define ADCC_FMT_WORD16    2'h1
`define ADCC_FMT_BYTE8     2'h2
`define ADCC_FMT_SERIAL    2'h3
// ==========================================
// Result width and conversion timing
`define ADCC_RES_W         18
`define ADCC_RESET_RESULT  18'h0_0000
// Conversion time in ns, and cycles at 100 ns per cycle
`define ADCC_CONV_NS       1500
`define ADCC_CLK_NS        100
`define ADCC_CONV_CYC      ((`ADCC_CONV_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)
// Low-power acquisition time in ns and cycles
`define ADCC_ACQ_NS        500
`define ADCC_ACQ_CYC       ((`ADCC_ACQ_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)
`define ADCC_CNT_W         8
`endif

// ==== rtl/adcc_ctrl.v ====
// What this block does
// - Result outputs driven only while chip select and read strobe both low.
// - External serial clock edges counted only while chip select is low.
// - High reset returns to idle and aborts any conversion.
// - Power-down lets current conversion finish, then refuses new starts.
// - Falling edge of start strobe enters hold and begins conversion.
// - Low-power mode: start still low after acquisition starts conversion.
// - Reference buffer enabled when disable input low, off when high.
// - Two select pins choose 18-bit, 16-bit, 8-bit or serial format.
// - 18-bit: line n is bit n; 16-bit words selected by word select.
// - Byte mode: bytes on lines 17..10, lines 0..9 released.
// - Busy high from start until result latched; fall marks ready.
// - Serial mode shifts result out MSB first on serial clock.
// - Coding select sets coding on parallel and serial paths.
`timescale 1ns/1ns
`include "adcc_regs.vh"

module adcc_ctrl
(
	// Clock and reset
	input  wire        clk_sys,
	input  wire        rst,
	// Conversion control
	input  wire        convert_start_n,
	input  wire        power_down_request,
	input  wire        low_power_sel,
	input  wire        fast_sel,
	input  wire        refbuf_disable,
	// Converter core
	input  wire [17:0] core_result,
	output reg         sample_hold_q,
	output reg         busy_q,
	output reg         powered_down_q,
	output wire        refbuf_enable,
	// Host bus
	input  wire        chip_select_n,
	input  wire        read_n,
	input  wire        bus_format_sel_hi,
	input  wire        bus_format_sel_lo,
	input  wire        output_coding_sel,
	input  wire        word_sel_bit0,
	input  wire        word_sel_bit1,
	input  wire        ext_sclk,
	output reg  [17:0] data_out_q,
	output reg  [17:0] data_oe_n_q,
	output reg         serial_result_out,
	output reg         serial_oe_n
);

	// ==========================================
	// Conversion sequencer
	localparam ST_IDLE = 2'h0;
	localparam ST_CONV = 2'h1;
	localparam ST_ACQ  = 2'h2;

	reg [1:0]             state_q;
	reg [`ADCC_CNT_W-1:0] cnt_q;
	reg                   start_n_q;
	reg [17:0]            result_q;
	wire                  low_power_mode;
	wire                  start_fall;

	assign low_power_mode = low_power_sel & ~fast_sel;
	assign start_fall     = start_n_q & ~convert_start_n;
	assign refbuf_enable  = ~refbuf_disable;

	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			// Abort anything in flight; result kept cleared
			state_q        <= ST_IDLE;
			cnt_q          <= {`ADCC_CNT_W{1'b0}};
			start_n_q      <= 1'b1;
			busy_q         <= 1'b0;
			sample_hold_q  <= 1'b0;
			powered_down_q <= 1'b0;
			result_q       <= `ADCC_RESET_RESULT;
		end
		else
		begin
			start_n_q <= convert_start_n;
			case (state_q)
			ST_IDLE:
			begin
				powered_down_q <= power_down_request;
				if (start_fall && !power_down_request)
				begin
					state_q       <= ST_CONV;
					sample_hold_q <= 1'b1;
					busy_q        <= 1'b1;
					cnt_q         <= {`ADCC_CNT_W{1'b0}};
				end
			end
			ST_CONV:
			begin
				// Power-down waits here until this conversion ends
				if (cnt_q == `ADCC_CONV_CYC - 1)
				begin
					result_q      <= core_result;
					busy_q        <= 1'b0;
					sample_hold_q <= 1'b0;
					cnt_q         <= {`ADCC_CNT_W{1'b0}};
					state_q       <= low_power_mode ? ST_ACQ : ST_IDLE;
				end
				else
					cnt_q <= cnt_q + 1'b1;
			end
			ST_ACQ:
			begin
				if (cnt_q == `ADCC_ACQ_CYC - 1)
				begin
					cnt_q <= {`ADCC_CNT_W{1'b0}};
					// Start held low through acquisition converts at once
					if (!convert_start_n && !power_down_request)
					begin
						state_q       <= ST_CONV;
						sample_hold_q <= 1'b1;
						busy_q        <= 1'b1;
					end
					else
						state_q <= ST_IDLE;
				end
				else
					cnt_q <= cnt_q + 1'b1;
			end
			default:
				state_q <= ST_IDLE;
			endcase
		end
	end

	// ==========================================
	// Output coding and bus formatting
	wire [17:0] coded;
	wire [1:0]  fmt;
	wire        enabled;

	assign coded   = {result_q[17] ^ ~output_coding_sel, result_q[16:0]};
	assign fmt     = {bus_format_sel_hi, bus_format_sel_lo};
	assign enabled = ~chip_select_n & ~read_n;

	reg [17:0] par_d;
	reg [17:0] oe_n_d;

	always @*
	begin
		par_d  = 18'h0_0000;
		oe_n_d = 18'h3_ffff;
		case (fmt)
		`ADCC_FMT_PAR18:
		begin
			par_d  = coded;
			oe_n_d = 18'h0_0000;
		end
		`ADCC_FMT_WORD16:
		begin
			// Lines 1..0 are inputs in this mode
			oe_n_d = 18'h0_0003;
			if (!word_sel_bit0)
				par_d = {coded[17:2], 2'b00};
			else
				par_d = {14'h0000, coded[1:0], 2'b00};
		end
		`ADCC_FMT_BYTE8:
		begin
			oe_n_d = 18'h0_03ff;
			case ({word_sel_bit0, word_sel_bit1})
			2'b00:   par_d = {coded[17:10], 10'h000};
			2'b01:   par_d = {coded[9:2], 10'h000};
			2'b10:   par_d = {6'h00, coded[1:0], 10'h000};
			default: par_d = {coded[1:0], 16'h0000};
			endcase
		end
		default:
			oe_n_d = 18'h3_ffff;
		endcase
		if (!enabled)
			oe_n_d = 18'h3_ffff;
	end

	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			data_out_q  <= 18'h0_0000;
			data_oe_n_q <= 18'h3_ffff;
		end
		else
		begin
			data_out_q  <= par_d;
			data_oe_n_q <= oe_n_d;
		end
	end

	// ==========================================
	// Serial shift path, external clock sampled synchronously
	reg [17:0] shift_q;
	reg        sclk_q;
	wire       sclk_rise;
	wire       serial_on;

	assign serial_on = (fmt == `ADCC_FMT_SERIAL) && enabled;
	assign sclk_rise = ext_sclk & ~sclk_q & ~chip_select_n;

	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			shift_q           <= 18'h0_0000;
			sclk_q            <= 1'b0;
			serial_result_out <= 1'b0;
			serial_oe_n       <= 1'b1;
		end
		else
		begin
			sclk_q      <= ext_sclk;
			serial_oe_n <= ~serial_on;
			if (state_q == ST_CONV && cnt_q == `ADCC_CONV_CYC - 1)
			begin
				// Reload on completion; coding applied at the load
				shift_q           <= {core_result[17] ^ ~output_coding_sel,
					core_result[16:0]};
				serial_result_out <= core_result[17] ^ ~output_coding_sel;
			end
			else if (serial_on && sclk_rise)
			begin
				shift_q           <= {shift_q[16:0], 1'b0};
				serial_result_out <= shift_q[16];
			end
		end
	end

endmodule // adcc_ctrl

// ==== tb/adcc_chk.sv ====
`timescale 1ns/1ns
module adcc_chk
(
	// Watched ports of the control block
	input wire        clk_sys,
	input wire        rst,
	input wire        convert_start_n,
	input wire        power_down_request,
	input wire        low_power_sel,
	input wire        fast_sel,
	input wire        refbuf_disable,
	input wire        chip_select_n,
	input wire        read_n,
	input wire        bus_format_sel_hi,
	input wire        bus_format_sel_lo,
	input wire        sample_hold_q,
	input wire        busy_q,
	input wire        refbuf_enable,
	input wire [17:0] data_oe_n_q,
	input wire        serial_oe_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire rd_on = !chip_select_n && !read_n;
	wire norm = !(low_power_sel && !fast_sel);
	property p_par; !(&data_oe_n_q) |-> $past(rd_on); endproperty
	a_par: assert property (p_par) else $error("bus driven");
	property p_ser; !serial_oe_n |-> $past(rd_on); endproperty
	a_ser: assert property (p_ser) else $error("serial driven");
	property p_go; $fell(convert_start_n) && !busy_q && norm
		&& !power_down_request |=> busy_q && sample_hold_q; endproperty
	a_go: assert property (p_go) else $error("no start");
	property p_len; $rose(busy_q) |-> busy_q[*8] ##7 busy_q ##1 !busy_q;
	endproperty
	a_len: assert property (p_len) else $error("busy length");
	property p_rst; disable iff (1'b0) rst |=> !busy_q && !sample_hold_q
		&& (&data_oe_n_q) && serial_oe_n; endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	property p_pd; power_down_request && !busy_q |=> !busy_q; endproperty
	a_pd: assert property (p_pd) else $error("start in pd");
	property p_buf; refbuf_enable == !refbuf_disable; endproperty
	a_buf: assert property (p_buf) else $error("refbuf");
	property p_byte; bus_format_sel_hi && !bus_format_sel_lo
		|=> &data_oe_n_q[9:3]; endproperty
	a_byte: assert property (p_byte) else $error("byte lines");
endmodule // adcc_chk

// ==== tb/adcc_core_model.sv ====
`timescale 1ns/1ns
module adcc_core_model
(
	// Hold handshake and result
	input  wire        clk_sys,
	input  wire        sample_hold_q,
	input  wire [17:0] analog_in,
	output wire [17:0] core_result
);
	logic [17:0] held_q = 18'h0_0000;
	logic        seen_q = 1'b0;
	always @(posedge clk_sys)
	begin
		seen_q <= sample_hold_q;
		if (sample_hold_q && !seen_q)
			held_q <= analog_in;
	end
	// Outside hold the core shows junk, so early sampling is caught
	assign core_result = seen_q ? held_q : ~held_q;
endmodule // adcc_core_model

// ==== tb/adcc_ctrl_bench.sv ====
`timescale 1ns/1ns
`include "adcc_regs.vh"
module adcc_ctrl_bench;
	logic clk_sys = 0, rst = 1, convert_start_n = 1, power_down_request = 0;
	logic low_power_sel = 0, fast_sel = 0, refbuf_disable = 0, ext_sclk = 0;
	logic chip_select_n = 1, read_n = 1, word_sel_bit0 = 0, word_sel_bit1 = 0;
	logic bus_format_sel_hi = 0, bus_format_sel_lo = 0, output_coding_sel = 1;
	logic [17:0] analog_in = 18'h2_d5a7;
	wire [17:0] core_result, data_out_q, data_oe_n_q;
	wire sample_hold_q, busy_q, refbuf_enable, serial_result_out, serial_oe_n;
	wire powered_down_q;
	int errors = 0, num_checks = 0, i;
	always #50 clk_sys = ~clk_sys;
	adcc_core_model u_core (.*);
	adcc_ctrl u_dut (.*);
	task tick(input int k);
		repeat (k) @(posedge clk_sys);
		#10;
	endtask
	task chk(input string nm, input logic [17:0] seen, exp);
		num_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task conv(input logic p);
		convert_start_n = 0;
		tick(2);
		chk("start", {busy_q, sample_hold_q}, 18'h0_0003);
		convert_start_n = 1;
		power_down_request = p;
		for (i = 0; busy_q !== 1'b0 && i < 40; i++)
			tick(1);
		// Busy was already high one cycle before the loop began counting
		chk("conv", 18'(i + 1), 18'(`ADCC_CONV_CYC));
		if (i == 40)
			wrap_up();
	endtask
	task rd(input logic [1:0] f, w, input logic [17:0] eo, ed);
		{bus_format_sel_hi, bus_format_sel_lo} = f;
		{word_sel_bit1, word_sel_bit0} = w;
		{chip_select_n, read_n} = 2'b00;
		tick(2);
		chk("oe_n", data_oe_n_q, eo);
		chk("data", data_out_q & ~eo, ed);
		{chip_select_n, read_n} = 2'b11;
		tick(2);
		chk("idle", data_oe_n_q, 18'h3_ffff);
	endtask
	initial
	begin
		tick(10);
		rst = 0;
		tick(2);
		chk("refbuf", refbuf_enable, 18'h0_0001);
		conv(0);
		rd(0, 0, 0, analog_in);
		rd(1, 0, 18'h0_0003, {analog_in[17:2], 2'b00});
		rd(1, 1, 18'h0_0003, {14'h0, analog_in[1:0], 2'b00});
		rd(2, 0, 18'h0_03ff, {analog_in[17:10], 10'h0});
		rd(2, 2, 18'h0_03ff, {analog_in[9:2], 10'h0});
		rd(2, 1, 18'h0_03ff, {6'h0, analog_in[1:0], 10'h0});
		rd(2, 3, 18'h0_03ff, {analog_in[1:0], 16'h0});
		output_coding_sel = 0;
		rd(0, 0, 0, analog_in ^ 18'h2_0000);
		// New sample with two's complement coding taken at the serial load
		analog_in = 18'h1_3c96;
		conv(1);
		output_coding_sel = 1;
		convert_start_n = 0;
		tick(3);
		chk("pd", busy_q, 18'h0_0000);
		chk("pdq", powered_down_q, 18'h0_0001);
		{convert_start_n, power_down_request, refbuf_disable} = 3'b101;
		{bus_format_sel_hi, bus_format_sel_lo, ext_sclk} = 3'b111;
		tick(2);
		chk("refbuf", refbuf_enable, 18'h0_0000);
		chk("pdq_off", powered_down_q, 18'h0_0000);
		{chip_select_n, read_n, ext_sclk} = 3'b000;
		tick(2);
		chk("soe", serial_oe_n, 18'h0_0000);
		chk("s_par", data_oe_n_q, 18'h3_ffff);
		for (i = 17; i >= 0; i--)
		begin
			if (i == 9)
			begin
				// A clock pulse with select high must not advance the data
				{chip_select_n, ext_sclk} = 2'b11;
				tick(2);
				{chip_select_n, ext_sclk} = 2'b00;
				tick(2);
			end
			chk("sdo", serial_result_out, analog_in[i] ^ (i == 17));
			ext_sclk = 1;
			tick(2);
			ext_sclk = 0;
			tick(2);
		end
		{chip_select_n, read_n, convert_start_n} = 3'b110;
		tick(2);
		{rst, convert_start_n} = 2'b11;
		tick(1);
		rst = 0;
		chk("abort", {busy_q, sample_hold_q}, 18'h0_0000);
		tick(2);
		// Low-power mode with start held low relaunches after acquisition
		low_power_sel = 1;
		convert_start_n = 0;
		tick(`ADCC_CONV_CYC + `ADCC_ACQ_CYC);
		chk("acq", busy_q, 18'h0_0000);
		tick(1);
		chk("relaunch", {busy_q, sample_hold_q}, 18'h0_0003);
		wrap_up();
	end
endmodule // adcc_ctrl_bench
bind adcc_ctrl adcc_chk u_chk (.*);
